/* design/adccfg_pkg.sv */
// package for the converter configuration block: offsets, fields, codes
package adccfg_pkg;
    // register byte offsets
    localparam logic [11:0] ADCCFG_CTRL_ONE_OFS = 12'h000;
    localparam logic [11:0] ADCCFG_STATUS_OFS = 12'h004;
    localparam logic [11:0] ADCCFG_RAW_OFS = 12'h008;
    localparam logic [11:0] ADCCFG_RESULT_OFS = 12'h00C;
    // field positions in the control register
    localparam int ADCCFG_JUSTIFY_BIT = 7;
    localparam int ADCCFG_CLKSEL_LSB = 4;
    localparam int ADCCFG_REFSEL_LSB = 0;
    // reset and implemented-bit mask
    localparam logic [7:0] ADCCFG_CTRL_RESET = 8'h00;
    localparam logic [7:0] ADCCFG_CTRL_MASK = 8'hF3;
    // conversion clock select codes
    localparam logic [2:0] ADCCFG_CS_DIV2 = 3'h0;
    localparam logic [2:0] ADCCFG_CS_DIV8 = 3'h1;
    localparam logic [2:0] ADCCFG_CS_DIV32 = 3'h2;
    localparam logic [2:0] ADCCFG_CS_RC_A = 3'h3;
    localparam logic [2:0] ADCCFG_CS_DIV4 = 3'h4;
    localparam logic [2:0] ADCCFG_CS_DIV16 = 3'h5;
    localparam logic [2:0] ADCCFG_CS_DIV64 = 3'h6;
    localparam logic [2:0] ADCCFG_CS_RC_B = 3'h7;
    // positive reference select codes
    localparam logic [1:0] ADCCFG_REF_SUPPLY = 2'h0;
    localparam logic [1:0] ADCCFG_REF_RSVD = 2'h1;
    localparam logic [1:0] ADCCFG_REF_PIN = 2'h2;
    localparam logic [1:0] ADCCFG_REF_FIXED = 2'h3;
    // one-hot route of the positive reference
    typedef enum logic [3:0] {
        ADCCFG_ROUTE_SUPPLY = 4'h1,
        ADCCFG_ROUTE_PIN = 4'h2,
        ADCCFG_ROUTE_FIXED = 4'h4,
        ADCCFG_ROUTE_RSVD = 4'h8
    } adccfg_route_t;
endpackage

/* design/adccfg_top.sv */
// converter configuration register with clock divider, reference and result formatting
`timescale 1ns/1ps
module adccfg_top
    import adccfg_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // converter side
    input wire logic i_adc_rc_oscillator,
    input wire logic [9:0] i_conv_result,
    output logic o_conv_clk,
    output logic [3:0] o_pos_ref_route,
    output logic [7:0] o_result_high_byte,
    output logic [7:0] o_result_low_byte
);

    logic [7:0] adc_control_one_reg;
    logic [5:0] div_cnt_reg;
    logic div_clk_reg;
    logic conv_clk_reg;
    logic [3:0] route_reg;
    logic [7:0] res_hi_reg;
    logic [7:0] res_lo_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [2:0] conv_clock_select;
    logic [1:0] pos_ref_select;
    logic result_justify_select;
    logic [5:0] half_period;
    logic access;
    logic wr_take;
    logic rc_selected;
    logic known_addr;

    // divider terminal count: half period of the divided clock minus one, in system clock cycles
    function automatic logic [5:0] adccfg_half(input logic [2:0] sel);
        logic [5:0] h;
        h = 6'h00;
        unique case (sel)
            ADCCFG_CS_DIV2: h = 6'h00;
            ADCCFG_CS_DIV4: h = 6'h01;
            ADCCFG_CS_DIV8: h = 6'h03;
            ADCCFG_CS_DIV16: h = 6'h07;
            ADCCFG_CS_DIV32: h = 6'h0F;
            ADCCFG_CS_DIV64: h = 6'h1F;
            default: h = 6'h00; // rc codes do not use the divider
        endcase
        return h;
    endfunction

    assign conv_clock_select = adc_control_one_reg[ADCCFG_CLKSEL_LSB +: 3];
    assign pos_ref_select = adc_control_one_reg[ADCCFG_REFSEL_LSB +: 2];
    assign result_justify_select = adc_control_one_reg[ADCCFG_JUSTIFY_BIT];
    assign half_period = adccfg_half(conv_clock_select);
    assign access = i_psel && i_penable && !pready_reg;
    // write lands only on the edge where the master sees pready high
    assign wr_take = i_psel && i_penable && pready_reg && i_pwrite && i_pstrb[0]
        && (i_paddr == ADCCFG_CTRL_ONE_OFS);
    assign rc_selected = (conv_clock_select == ADCCFG_CS_RC_A)
        || (conv_clock_select == ADCCFG_CS_RC_B);
    assign known_addr = (i_paddr == ADCCFG_CTRL_ONE_OFS) || (i_paddr == ADCCFG_STATUS_OFS)
        || (i_paddr == ADCCFG_RAW_OFS) || (i_paddr == ADCCFG_RESULT_OFS);

    // control register; only the low byte lane carries it
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            adc_control_one_reg <= ADCCFG_CTRL_RESET;
        end else if (wr_take) begin
            adc_control_one_reg <= i_pwdata[7:0] & ADCCFG_CTRL_MASK;
        end
    end

    // apb answer: one wait state, pready high in the access phase's second cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access && !known_addr;
            prdata_reg <= 32'h0000_0000;
            if (access && !i_pwrite) begin
                unique case (i_paddr)
                    ADCCFG_CTRL_ONE_OFS: prdata_reg <= {24'h000000, adc_control_one_reg};
                    ADCCFG_STATUS_OFS: prdata_reg <= {26'h0000000, conv_clk_reg, route_reg,
                        result_justify_select};
                    ADCCFG_RAW_OFS: prdata_reg <= {22'h000000, i_conv_result};
                    ADCCFG_RESULT_OFS: prdata_reg <= {16'h0000, res_hi_reg, res_lo_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // free-running divider; toggles every half period
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            div_cnt_reg <= 6'h00;
            div_clk_reg <= 1'b0;
        end else if (div_cnt_reg >= half_period) begin
            div_cnt_reg <= 6'h00;
            div_clk_reg <= ~div_clk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // conversion clock mux; rc input is sampled, so it must be slower than mclk
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            conv_clk_reg <= 1'b0;
        end else if (rc_selected) begin
            conv_clk_reg <= i_adc_rc_oscillator;
        end else begin
            conv_clk_reg <= div_clk_reg;
        end
    end

    // positive reference route, one-hot
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            route_reg <= ADCCFG_ROUTE_SUPPLY;
        end else begin
            unique case (pos_ref_select)
                ADCCFG_REF_SUPPLY: route_reg <= ADCCFG_ROUTE_SUPPLY;
                ADCCFG_REF_PIN: route_reg <= ADCCFG_ROUTE_PIN;
                ADCCFG_REF_FIXED: route_reg <= ADCCFG_ROUTE_FIXED;
                ADCCFG_REF_RSVD: route_reg <= ADCCFG_ROUTE_RSVD; // reserved, flagged only
            endcase
        end
    end

    // result formatting across high and low bytes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            res_hi_reg <= 8'h00;
            res_lo_reg <= 8'h00;
        end else if (result_justify_select) begin
            res_hi_reg <= {6'h00, i_conv_result[9:8]};
            res_lo_reg <= i_conv_result[7:0];
        end else begin
            res_hi_reg <= i_conv_result[9:2];
            res_lo_reg <= {i_conv_result[1:0], 6'h00};
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_conv_clk = conv_clk_reg;
    assign o_pos_ref_route = route_reg;
    assign o_result_high_byte = res_hi_reg;
    assign o_result_low_byte = res_lo_reg;

endmodule

/* dv/adccfg_sva.sv */
// port assertions for the converter configuration block
`timescale 1ns/1ps
module adccfg_sva (
    input wire logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_conv_clk,
    input wire logic [11:0] i_paddr,
    input wire logic [9:0] i_conv_result,
    input wire logic [31:0] o_prdata,
    input wire logic [3:0] o_pos_ref_route,
    input wire logic [7:0] o_result_high_byte, o_result_low_byte
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready late");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready held");
    a_rsvd_read_zero: assert property (o_pready && i_paddr == 12'h000 && !i_pwrite
        |-> (o_prdata & 32'hFFFFFF0C) == 32'h0)
        else $error("unimplemented bits read set");
    a_reset_clears: assert property ($fell(i_rst) |-> o_pos_ref_route == 4'h1 && !o_conv_clk)
        else $error("outputs not cleared");
    a_route_onehot: assert property ($onehot(o_pos_ref_route))
        else $error("route not one-hot");
    a_unmapped_err: assert property (o_pready && i_paddr > 12'h00C |-> o_pslverr)
        else $error("unmapped access accepted");
    a_result_format: assert property (!$past(i_rst) |->
        {o_result_high_byte, o_result_low_byte} == {6'h0, $past(i_conv_result)} ||
        {o_result_high_byte, o_result_low_byte} == {$past(i_conv_result), 6'h0})
        else $error("result bytes misformatted");
endmodule
bind adccfg_top adccfg_sva adccfg_sva_i (.*);

/* dv/adccfg_top_tb.sv */
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("FAIL %0t %h %h", $time, (a), (b)); end end
module adccfg_top_tb;
    import adccfg_pkg::*;
    logic i_mclk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, rc = 0, rdy, err, re, cclk, v;
    logic [11:0] addr = 0;
    logic [31:0] wd = 0, rd, prd;
    logic [3:0] strb = 4'hF, route;
    logic [9:0] res = 0;
    logic [7:0] hi, lo;
    int error_cnt = 0, n_checks = 0, h, rcn = 0;
    adccfg_top adccfg_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(strb), .o_prdata(prd),
        .o_pready(rdy), .o_pslverr(err), .i_adc_rc_oscillator(rc), .i_conv_result(res),
        .o_conv_clk(cclk), .o_pos_ref_route(route), .o_result_high_byte(hi),
        .o_result_low_byte(lo));
    initial forever #5 i_mclk = ~i_mclk;
    // rc source with a half period of three clocks
    always @(posedge i_mclk) begin
        rcn <= (rcn == 2) ? 0 : rcn + 1;
        if (rcn == 2) rc <= ~rc;
    end
    // apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge i_mclk);
        pen <= 1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do @(posedge i_mclk); while (rdy !== 1'b1);
        rd = prd;
        re = err;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic t_regs;
        xfer(0, ADCCFG_CTRL_ONE_OFS, 0);
        `CHK(rd, 32'h0)
        xfer(1, ADCCFG_CTRL_ONE_OFS, 32'hFFFFFFFF);
        strb <= 4'hE;
        xfer(1, ADCCFG_CTRL_ONE_OFS, 32'h0);
        strb <= 4'hF;
        xfer(0, ADCCFG_CTRL_ONE_OFS, 0);
        `CHK(rd, 32'hF3)
        xfer(0, 12'h010, 0);
        `CHK({re, rd}, {1'b1, 32'h0})
        i_rst <= 1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 0;
        xfer(0, ADCCFG_CTRL_ONE_OFS, 0);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_clock;
        int half [8] = '{1, 4, 16, 3, 2, 8, 32, 3};
        for (int c = 0; c < 8; c++) begin
            xfer(1, ADCCFG_CTRL_ONE_OFS, c << 4);
            // first two passes skip a mux switch and a part-counted divider phase
            repeat (3) begin
                v = cclk;
                h = 0;
                while (cclk === v && h < 99) begin @(posedge i_mclk); h++; end
            end
            `CHK(h, half[c])
        end
    endtask
    task automatic t_ref;
        logic [3:0] rt [4] = '{4'h1, 4'h8, 4'h2, 4'h4};
        for (int c = 0; c < 4; c++) begin
            xfer(1, ADCCFG_CTRL_ONE_OFS, c);
            repeat (2) @(posedge i_mclk);
            `CHK(route, rt[c])
        end
    endtask
    task automatic t_fmt;
        res <= 10'h2A5;
        xfer(1, ADCCFG_CTRL_ONE_OFS, 32'h80);
        repeat (2) @(posedge i_mclk);
        `CHK({hi, lo}, 16'h02A5)
        xfer(0, ADCCFG_RESULT_OFS, 0);
        `CHK(rd, 32'h02A5)
        xfer(0, ADCCFG_RAW_OFS, 0);
        `CHK(rd, 32'h02A5)
        xfer(1, ADCCFG_CTRL_ONE_OFS, 32'h0);
        repeat (2) @(posedge i_mclk);
        `CHK({hi, lo}, 16'hA940)
        xfer(0, ADCCFG_STATUS_OFS, 0);
        `CHK(rd & 32'h1F, 32'h02)
    endtask
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst <= 0;
        t_regs;
        t_clock;
        t_ref;
        t_fmt;
        conclude;
    end
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge i_mclk);
        error_cnt++;
        conclude;
    end
endmodule
